/* File: logic/pfc_ctrl.sv */
// host controller issuing protected flash command sequences and polling status
// Function
// [R1] commands are written by pulsing write strobe low under chip select
// [R2] address must be stable when the later falling strobe edge occurs
// [R3] data must be stable at the first rising strobe edge
// [R4] array data is read only with select and output gate both low
// [R5] select stays high whenever no bus cycle runs
// [R6] host releases the data bus whenever it reads
// [R7] program single bytes only, into sectors that are already erased
// [R8] program is three preamble writes then address and data write
// [R9] program completes within twenty microseconds; host times out beyond
// [R10] while busy, reads show only the two status bits
// [R11] no command cycles are written while a program runs
// [R12] sector erase is six writes ending with 30h at sector address
// [R13] sector address goes on the last fall, erase code on last rise
// [R14] sector erase begins after the sixth strobe pulse
// [R15] no command cycles are written while a sector erase runs
// [R16] chip erase is six writes ending with 10h at 5555h
// [R17] chip erase starts on the sixth strobe rising edge
// [R18] during chip erase host only polls status, writes nothing
// [R19] status polling starts right after the launching strobe rise
// [R20] on apparent completion re-read twice; both must be valid
// [R21] inverted bit shows complement while programming, zero while erasing
// [R22] alternating bit toggles each read while busy, stops when done
// [R23] a mismatched sequence cycle makes the device drop back to reads
// [R24] after completion the device accepts reads and new sequences again
`include "pfc_cfg.svh"
module pfc_ctrl import pfc_pkg::*; #(
    parameter int AW = 19,
    parameter int unsigned ERA_MAX_CYC = `PFC_ERA_MAX_DEF,
    parameter logic [15:0] ULK_A0 = 16'h0000,
    parameter logic [15:0] ULK_A1 = 16'h0000,
    parameter logic [7:0] ULK_D0 = 8'h00,
    parameter logic [7:0] ULK_D1 = 8'h00,
    parameter logic [7:0] PGM_D = 8'h00,
    parameter logic [7:0] ERA_D = 8'h00
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire pfc_op_t cmd_op,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_err,
    output logic busy,
    output logic [AW-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_i
);
    if (AW < 16 || AW > 24) begin : g_chk
        $error("address width outside 16..24");
    end
    localparam logic [31:0] PGM_LIM = 32'(`PFC_PGM_MAX_CYC + `PFC_POLL_SLACK);
    localparam logic [31:0] ERA_LIM = 32'(ERA_MAX_CYC) + 32'(`PFC_POLL_SLACK);

    // address and data of one preamble step
    function automatic logic [23:0] step_pair(input logic [2:0] idx);
        unique case (idx)
            3'h0, 3'h3: step_pair = {ULK_A0, ULK_D0};
            3'h1, 3'h4: step_pair = {ULK_A1, ULK_D1};
            default: step_pair = {ULK_A0, PGM_D};
        endcase
    endfunction

    // status byte says the operation is over
    function automatic logic settled(input logic [7:0] now, input logic [7:0] prev,
                                     input logic [7:0] want);
        settled = (now[`PFC_BIT_TOG] == prev[`PFC_BIT_TOG]) && // R22
                  (now[`PFC_BIT_INV] == want[`PFC_BIT_INV]); // R21
    endfunction

    pfc_main_t st_q, st_d;
    pfc_op_t op_q, op_d;
    logic [AW-1:0] adr_q, adr_d, ca_q, ca_d;
    logic [7:0] dat_q, dat_d, cd_q, cd_d, prev_q, prev_d, want;
    logic [2:0] step_q, step_d, last;
    logic [1:0] rr_q, rr_d;
    logic [31:0] cnt_q, cnt_d, lim;
    logic first_q, first_d, go_q, go_d, cw_q, cw_d;
    logic rdy_d, rv_d, re_d;
    logic [7:0] rdat_d;
    logic cyc_done;
    logic [7:0] cyc_rdata;
    logic [23:0] pair;

    pfc_cycle #(.AW(AW)) u_cycle (
        .clk(clk),
        .reset(reset),
        .start(go_q),
        .wr(cw_q),
        .addr(ca_q),
        .wdata(cd_q),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .flash_addr(flash_addr),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_i(flash_dq_i)
    );

    always_comb begin
        last = (op_q == PFC_OP_PGM) ? `PFC_PGM_LAST : `PFC_ERA_LAST;
        want = (op_q == PFC_OP_PGM) ? dat_q : 8'hFF; // R21
        lim = (op_q == PFC_OP_PGM) ? PGM_LIM : ERA_LIM;
        st_d = st_q;
        op_d = op_q;
        adr_d = adr_q;
        dat_d = dat_q;
        ca_d = ca_q;
        cd_d = cd_q;
        prev_d = prev_q;
        step_d = step_q;
        rr_d = rr_q;
        cnt_d = cnt_q;
        first_d = first_q;
        go_d = 1'b0;
        cw_d = cw_q;
        rdy_d = 1'b0;
        rv_d = 1'b0;
        re_d = 1'b0;
        rdat_d = rsp_data;
        pair = step_pair(step_q + 3'h1);
        unique case (st_q)
            PFC_M_IDLE: begin
                rdy_d = 1'b1;
                if (cmd_valid && cmd_ready) begin
                    rdy_d = 1'b0;
                    op_d = cmd_op;
                    adr_d = cmd_addr;
                    dat_d = cmd_data;
                    step_d = 3'h0;
                    go_d = 1'b1;
                    cw_d = (cmd_op != PFC_OP_READ); // R1
                    if (cmd_op == PFC_OP_READ) begin
                        st_d = PFC_M_RD;
                        ca_d = cmd_addr; // R4
                    end else begin
                        st_d = PFC_M_WR; // R8 R12 R16
                        ca_d = AW'(ULK_A0);
                        cd_d = ULK_D0;
                    end
                end
            end
            PFC_M_RD: if (cyc_done) begin
                st_d = PFC_M_IDLE;
                rv_d = 1'b1;
                rdat_d = cyc_rdata;
                rdy_d = 1'b1;
            end
            PFC_M_WR: if (cyc_done) begin
                go_d = 1'b1;
                if (step_q == last) begin
                    // operation launched by this rise; start polling
                    st_d = PFC_M_POLL; // R14 R17 R19
                    cw_d = 1'b0;
                    ca_d = adr_q;
                    cnt_d = 32'h0;
                    first_d = 1'b1;
                end else begin
                    step_d = step_q + 3'h1;
                    ca_d = AW'(pair[23:8]);
                    cd_d = pair[7:0];
                    if (step_q + 3'h1 == last) begin
                        unique case (op_q)
                            PFC_OP_PGM: begin
                                ca_d = adr_q; // R7 R8
                                cd_d = dat_q;
                            end
                            PFC_OP_SECT: begin
                                ca_d = {adr_q[AW-1:`PFC_SECT_LSB], // R13
                                        {`PFC_SECT_LSB{1'b0}}};
                                cd_d = `PFC_SECT_CODE;
                            end
                            default: begin
                                ca_d = AW'(`PFC_CHIP_ADDR); // R16
                                cd_d = `PFC_CHIP_CODE;
                            end
                        endcase
                    end else if (step_q + 3'h1 == 3'h2 && op_q != PFC_OP_PGM) begin
                        cd_d = ERA_D;
                    end
                end
            end
            PFC_M_POLL, PFC_M_CHECK: begin
                // only reads go out while the device is busy
                cnt_d = cnt_q + 32'h1; // R10 R11 R15 R18
                if (cnt_q >= lim) begin
                    st_d = PFC_M_IDLE; // R9
                    rv_d = 1'b1;
                    re_d = 1'b1;
                    rdat_d = prev_q;
                    rdy_d = 1'b1;
                end else if (cyc_done) begin
                    prev_d = cyc_rdata;
                    first_d = 1'b0;
                    go_d = 1'b1;
                    if (st_q == PFC_M_POLL) begin
                        if (!first_q && settled(cyc_rdata, prev_q, want)) begin
                            st_d = PFC_M_CHECK; // R20
                            rr_d = 2'h0;
                        end
                    end else if (!settled(cyc_rdata, prev_q, want)) begin
                        st_d = PFC_M_POLL; // R20
                    end else if (rr_q + 2'h1 == `PFC_REREADS) begin
                        // both re-reads valid, device back in read mode
                        st_d = PFC_M_IDLE; // R20 R24
                        go_d = 1'b0;
                        rv_d = 1'b1;
                        rdat_d = cyc_rdata;
                        rdy_d = 1'b1;
                    end else begin
                        rr_d = rr_q + 2'h1;
                    end
                end
            end
            default: begin
                // R23: any stray state is dropped like an aborted sequence
                st_d = PFC_M_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= PFC_M_IDLE;
            op_q <= PFC_OP_READ;
            adr_q <= '0;
            dat_q <= 8'h00;
            ca_q <= '0;
            cd_q <= 8'h00;
            prev_q <= 8'h00;
            step_q <= 3'h0;
            rr_q <= 2'h0;
            cnt_q <= 32'h0;
            first_q <= 1'b0;
            go_q <= 1'b0;
            cw_q <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_data <= 8'h00;
            busy <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            adr_q <= adr_d;
            dat_q <= dat_d;
            ca_q <= ca_d;
            cd_q <= cd_d;
            prev_q <= prev_d;
            step_q <= step_d;
            rr_q <= rr_d;
            cnt_q <= cnt_d;
            first_q <= first_d;
            go_q <= go_d;
            cw_q <= cw_d;
            cmd_ready <= rdy_d;
            rsp_valid <= rv_d;
            rsp_err <= re_d;
            rsp_data <= rdat_d;
            busy <= (st_d != PFC_M_IDLE);
        end
    end

    a_poll_no_write: assert property (@(posedge clk) disable iff (reset) // R11
        (st_q == PFC_M_POLL || st_q == PFC_M_CHECK) && go_q |-> !cw_q)
        else $error("write issued while device busy");
    a_launch_poll: assert property (@(posedge clk) disable iff (reset) // R19
        st_q == PFC_M_WR && cyc_done && step_q == last && cnt_q < lim |=>
        st_q == PFC_M_POLL && go_q && !cw_q)
        else $error("poll not started after last write");
    a_pgm_timeout: assert property (@(posedge clk) disable iff (reset) // R9
        st_q == PFC_M_POLL && op_q == PFC_OP_PGM && cnt_q >= PGM_LIM |=>
        rsp_valid && rsp_err)
        else $error("program timeout not flagged");
    a_ok_after_rereads: assert property (@(posedge clk) disable iff (reset) // R20
        rsp_valid && !rsp_err && op_q != PFC_OP_READ |-> $past(st_q) == PFC_M_CHECK &&
        $past(rr_q) == 2'h1)
        else $error("completion without two re-reads");
    a_rsp_pulse: assert property (@(posedge clk) disable iff (reset) // R24
        rsp_valid |-> cmd_ready ##1 !rsp_valid)
        else $error("response not a single pulse");
    a_seq_steps: assert property (@(posedge clk) disable iff (reset) // R8
        st_q == PFC_M_WR |-> step_q <= last)
        else $error("sequence longer than allowed");
endmodule

/* File: inc/pfc_cfg.svh */
// timing, codes and field positions for the flash command port host
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_CLK_NS 10
`define PFC_WE_NS 40
`define PFC_WE_CYC ((`PFC_WE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_RD_NS 90
`define PFC_RD_CYC ((`PFC_RD_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_SYNC_CYC 2
`define PFC_PGM_MAX_NS 20000
`define PFC_PGM_MAX_CYC (`PFC_PGM_MAX_NS / `PFC_CLK_NS)
`define PFC_POLL_SLACK 256
`define PFC_ERA_MAX_DEF 10000000
`define PFC_CHIP_ADDR 16'h5555
`define PFC_SECT_CODE 8'h30
`define PFC_CHIP_CODE 8'h10
`define PFC_PGM_LAST 3'h3
`define PFC_ERA_LAST 3'h5
`define PFC_SECT_LSB 12
`define PFC_BIT_INV 7
`define PFC_BIT_TOG 6
`define PFC_REREADS 2'h2
`endif

/* File: inc/pfc_pkg.sv */
// types for the flash command port host
package pfc_pkg;
    typedef enum logic [1:0] {
        PFC_OP_READ = 2'h0,
        PFC_OP_PGM = 2'h1,
        PFC_OP_SECT = 2'h2,
        PFC_OP_CHIP = 2'h3
    } pfc_op_t;
    typedef enum logic [2:0] {
        PFC_C_IDLE = 3'h0,
        PFC_C_SETUP = 3'h1,
        PFC_C_STROBE = 3'h3,
        PFC_C_HOLD = 3'h2,
        PFC_C_END = 3'h6,
        PFC_C_READ = 3'h7
    } pfc_cyc_t;
    typedef enum logic [2:0] {
        PFC_M_IDLE = 3'h0,
        PFC_M_WR = 3'h1,
        PFC_M_POLL = 3'h3,
        PFC_M_CHECK = 3'h2,
        PFC_M_RD = 3'h6
    } pfc_main_t;
endpackage

/* File: logic/pfc_cycle.sv */
// one read or write bus cycle on the flash pins
`include "pfc_cfg.svh"
module pfc_cycle import pfc_pkg::*; #(
    parameter int AW = 19
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic wr,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    output logic [AW-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_i
);
    localparam logic [7:0] WE_N = 8'(`PFC_WE_CYC - 1);
    localparam logic [7:0] RD_N = 8'(`PFC_RD_CYC + `PFC_SYNC_CYC - 1);
    pfc_cyc_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d, rd_q, rd_d, meta_q, sync_q;
    logic wr_q, wr_d, done_d;
    logic [AW-1:0] a_q, a_d;
    logic [7:0] dq_q, dq_d;
    logic ce_d, oe_d, we_d, dqoe_d;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        a_d = a_q;
        dq_d = dq_q;
        rd_d = rd_q;
        done_d = 1'b0;
        unique case (st_q)
            PFC_C_IDLE: if (start) begin
                st_d = PFC_C_SETUP;
                wr_d = wr;
                a_d = addr;
                dq_d = wdata;
            end
            PFC_C_SETUP: begin
                st_d = wr_q ? PFC_C_STROBE : PFC_C_READ;
                cnt_d = 8'h00;
            end
            PFC_C_STROBE: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == WE_N) st_d = PFC_C_HOLD;
            end
            PFC_C_HOLD: st_d = PFC_C_END;
            PFC_C_READ: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == RD_N) begin
                    st_d = PFC_C_END;
                    rd_d = sync_q;
                end
            end
            PFC_C_END: begin
                st_d = PFC_C_IDLE;
                done_d = 1'b1;
            end
        endcase
        // pins follow the next state
        ce_d = (st_d == PFC_C_IDLE) || (st_d == PFC_C_END); // R5
        we_d = (st_d != PFC_C_STROBE); // R1
        oe_d = (st_d != PFC_C_READ); // R4
        dqoe_d = wr_d && !ce_d; // R6
    end
    always_ff @(posedge clk) begin
        meta_q <= flash_dq_i;
        sync_q <= meta_q;
        if (reset) begin
            st_q <= PFC_C_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            a_q <= '0;
            dq_q <= 8'h00;
            rd_q <= 8'h00;
            done <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            a_q <= a_d;
            dq_q <= dq_d;
            rd_q <= rd_d;
            done <= done_d;
            flash_ce_n <= ce_d;
            flash_oe_n <= oe_d;
            flash_we_n <= we_d;
            flash_dq_oe <= dqoe_d;
        end
    end
    assign flash_addr = a_q;
    assign flash_dq_o = dq_q;
    assign rdata = rd_q;

    a_we_under_ce: assert property (@(posedge clk) disable iff (reset) // R1
        !flash_we_n |-> !flash_ce_n) else $error("strobe low without select");
    a_addr_held_strobe: assert property (@(posedge clk) disable iff (reset) // R2
        $past(!flash_we_n) && !flash_we_n |-> $stable(flash_addr))
        else $error("address moved during strobe");
    a_data_at_rise: assert property (@(posedge clk) disable iff (reset) // R3
        $rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n && $stable(flash_dq_o))
        else $error("data not held at strobe rise");
    a_no_drive_read: assert property (@(posedge clk) disable iff (reset) // R6
        !flash_oe_n |-> !flash_dq_oe && !flash_ce_n && flash_we_n)
        else $error("host drives bus during read");
    a_read_window: assert property (@(posedge clk) disable iff (reset) // R4
        $fell(flash_oe_n) |-> !flash_oe_n [*8])
        else $error("read gate too short");
    a_idle_deselect: assert property (@(posedge clk) disable iff (reset) // R5
        st_q == PFC_C_IDLE |-> flash_ce_n && flash_oe_n && flash_we_n)
        else $error("select active while idle");
endmodule

/* File: testbench/pfc_flash_model.sv */
// behavioural model of the byte-wide flash behind the command port
module pfc_flash_model #(
    parameter logic [15:0] ULK_A0 = 16'h0000,
    parameter logic [15:0] ULK_A1 = 16'h0000,
    parameter logic [7:0] ULK_D0 = 8'h00,
    parameter logic [7:0] ULK_D1 = 8'h00,
    parameter logic [7:0] PGM_D = 8'h00,
    parameter logic [7:0] ERA_D = 8'h00
) (
    input wire logic [15:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [15:0] lat_addr;
    logic [7:0] lat_data;
    logic [15:0] op_addr;
    logic [7:0] op_data;
    logic [1:0] op_kind;
    logic [2:0] step;
    logic busy;
    logic tog;
    int prog_ns = 5000;
    int era_ns = 8000;
    int wr_cnt = 0;
    int busy_wr = 0;
    wire wstb = ce_n | we_n;
    wire rstb = ce_n | oe_n;
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
        step = 3'h0;
        busy = 1'b0;
        tog = 1'b0;
        dq_out = 8'h00;
    end
    // address on the later fall, data on the earlier rise
    always @(negedge wstb) lat_addr = addr;
    always @(posedge wstb) begin
        lat_data = dq_in;
        wr_cnt++;
        if (busy) begin
            busy_wr++;
        end else begin
            case (step)
                3'h0, 3'h3: step = (lat_addr === ULK_A0 && lat_data === ULK_D0)
                    ? step + 3'h1 : 3'h0;
                3'h1, 3'h4: step = (lat_addr === ULK_A1 && lat_data === ULK_D1)
                    ? step + 3'h1 : 3'h0;
                3'h2: step = lat_addr != ULK_A0 ? 3'h0 : lat_data == PGM_D ? 3'h6
                    : lat_data == ERA_D ? 3'h3 : 3'h0;
                3'h6: begin
                    op_kind = 2'h0;
                    op_addr = lat_addr;
                    op_data = lat_data;
                    busy = 1'b1;
                    step = 3'h0;
                end
                3'h5: begin
                    op_addr = lat_addr;
                    op_data = 8'hFF;
                    if (lat_data == 8'h30) begin
                        op_kind = 2'h1;
                        busy = 1'b1;
                    end else if (lat_data == 8'h10 && lat_addr == 16'h5555) begin
                        op_kind = 2'h2;
                        busy = 1'b1;
                    end
                    step = 3'h0;
                end
                default: step = 3'h0;
            endcase
        end
    end
    // internal operation runs to its end, then normal reads resume
    always @(posedge busy) begin
        #(op_kind == 2'h0 ? prog_ns : era_ns);
        for (int i = 0; i < 65536; i++) begin
            if (op_kind == 2'h2 || (op_kind == 2'h1 && i[15:12] == op_addr[15:12])) begin
                mem[i] = 8'hFF;
            end
        end
        if (op_kind == 2'h0) mem[op_addr] = mem[op_addr] & op_data;
        busy = 1'b0;
    end
    always @(negedge rstb) begin
        if (busy) begin
            tog = ~tog;
            dq_out = {op_kind == 2'h0 ? ~op_data[7] : 1'b0, tog, 6'h00};
        end else begin
            dq_out = mem[addr];
        end
    end
    // released bus shows the inverse of the last byte
    always @(posedge rstb) dq_out = ~dq_out;
    assign dq_oe = !rstb;
endmodule

/* File: testbench/test_pfc_ctrl.sv */
// self-checking bench for the flash command port host
module test_pfc_ctrl import pfc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, cmd_valid, cmd_ready, rsp_valid, rsp_err, busy, er;
    pfc_op_t cmd_op;
    logic [15:0] cmd_addr, flash_addr;
    logic [7:0] cmd_data, rsp_data, flash_dq_o, flash_dq_i, mdl_dq, rd;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    localparam logic [15:0] UA0 = 16'h5555;
    localparam logic [15:0] UA1 = 16'h2AAA;
    localparam logic [7:0] UD0 = 8'hC3;
    localparam logic [7:0] UD1 = 8'h3C;
    localparam logic [7:0] UPG = 8'hA5;
    localparam logic [7:0] UER = 8'h5A;
    localparam int ERA_CYC = 2000;
    int mismatches = 0;
    int total_checks = 0;
    assign flash_dq_i = flash_dq_oe ? flash_dq_o : mdl_dq;
    pfc_ctrl #(.AW(16), .ERA_MAX_CYC(ERA_CYC), .ULK_A0(UA0), .ULK_A1(UA1),
        .ULK_D0(UD0), .ULK_D1(UD1), .PGM_D(UPG), .ERA_D(UER)) dut (.clk(clk),
        .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_err(rsp_err), .busy(busy), .flash_addr(flash_addr),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));
    pfc_flash_model #(.ULK_A0(UA0), .ULK_A1(UA1), .ULK_D0(UD0), .ULK_D1(UD1),
        .PGM_D(UPG), .ERA_D(UER)) mdl (.addr(flash_addr), .ce_n(flash_ce_n),
        .oe_n(flash_oe_n), .we_n(flash_we_n), .dq_in(flash_dq_i), .dq_out(mdl_dq),
        .dq_oe());
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_int(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic do_op(input pfc_op_t op, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        check_bit("busy after take", 1'b1, busy);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 30000) begin
            n++;
            @(negedge clk);
        end
        check_bit("response", 1'b1, rsp_valid);
        rd = rsp_data;
        er = rsp_err;
    endtask
    task automatic t_program(input logic [15:0] a, input logic [7:0] d);
        int w;
        w = mdl.wr_cnt;
        do_op(PFC_OP_PGM, a, d);
        check_int("program writes", 4, mdl.wr_cnt - w);
        check_bit("program error", 1'b0, er);
        check_byte("program status", d, rd);
        do_op(PFC_OP_READ, a, 8'h00);
        check_byte("program readback", d, rd);
    endtask
    task automatic t_erase(input pfc_op_t op, input logic [15:0] a, input logic [15:0] la,
        input logic [7:0] code, input logic [15:0] keep, input logic [7:0] kd);
        int w;
        w = mdl.wr_cnt;
        do_op(op, a, 8'h00);
        check_int("erase writes", 6, mdl.wr_cnt - w);
        check_bit("erase error", 1'b0, er);
        check_byte("erase status", 8'hFF, rd);
        check_byte("erase code", code, mdl.lat_data);
        check_byte("erase addr hi", la[15:8], mdl.lat_addr[15:8]);
        check_byte("erase addr lo", la[7:0], mdl.lat_addr[7:0]);
        do_op(PFC_OP_READ, a, 8'h00);
        check_byte("erased byte", 8'hFF, rd);
        do_op(PFC_OP_READ, keep, 8'h00);
        check_byte("other byte", kd, rd);
    endtask
    task automatic t_timeout(input pfc_op_t op, input logic [15:0] a, input logic [7:0] d);
        int n;
        mdl.prog_ns = 30000;
        mdl.era_ns = 40000;
        do_op(op, a, d);
        check_bit("timeout error", 1'b1, er);
        n = 0;
        while (mdl.busy && n < 5000) begin
            n++;
            @(negedge clk);
        end
        mdl.prog_ns = 5000;
        mdl.era_ns = 8000;
        do_op(PFC_OP_READ, a, 8'h00);
        check_byte("read after timeout", d, rd);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400000;
        mismatches++;
        results();
    end
    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = PFC_OP_READ;
        cmd_addr = 16'h0000;
        cmd_data = 8'h00;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check_bit("select idle", 1'b1, flash_ce_n);
        do_op(PFC_OP_READ, 16'h1234, 8'h00);
        check_byte("erased read", 8'hFF, rd);
        t_program(16'h1234, 8'h3C);
        t_program(16'h2010, 8'hC5);
        mdl.prog_ns = 15000;
        t_program(16'h2011, 8'h81);
        t_erase(PFC_OP_SECT, 16'h1234, 16'h1000, 8'h30, 16'h2010, 8'hC5);
        t_erase(PFC_OP_CHIP, 16'h0000, 16'h5555, 8'h10, 16'h2011, 8'hFF);
        t_timeout(PFC_OP_SECT, 16'h3000, 8'hFF);
        t_timeout(PFC_OP_PGM, 16'h3001, 8'h5A);
        check_int("writes while busy", 0, mdl.busy_wr);
        results();
    end
endmodule
